// File: core/ivp_regs.vh
// Vector numbers, levels and widths for the vector priority block
`ifndef IVP_REGS_VH
`define IVP_REGS_VH
`define IVP_NUM_VEC      47
`define IVP_VEC_W        6
`define IVP_LVL_W        2
`define IVP_ADDR_W       21
`define IVP_VEC_ADDR_W   19
`define IVP_BASE_RESET   21'h000000
`define IVP_LVL_FIXED    2'h3
`define IVP_LVL_DBG_MIN  2'h1
`define IVP_LVL_DBG_MAX  2'h3
`define IVP_LVL_PER_MAX  2'h2
`define IVP_VEC_FIRST    6'h02
`define IVP_VEC_LAST_EXC 6'h05
`define IVP_VEC_DBG_LO   6'h06
`define IVP_VEC_DBG_HI   6'h0b
`define IVP_VEC_SW2      6'h0e
`define IVP_VEC_SW1      6'h0f
`define IVP_VEC_SW0      6'h10
`define IVP_VEC_LVD      6'h14
`define IVP_VEC_FLASH_LO 6'h16
`define IVP_VEC_FLASH_HI 6'h18
`define IVP_VEC_CAN_LO   6'h1a
`define IVP_VEC_CAN_HI   6'h1d
`define IVP_VEC_SPI_LO   6'h26
`define IVP_VEC_SPI_HI   6'h29
`define IVP_VEC_SER_LO   6'h2a
`define IVP_VEC_SER_HI   6'h2e
// Reserved vectors 0,1,8,12,13,19,25,36,37,44
`define IVP_RSV_MASK     47'h1030_0208_3103
`endif

// File: core/ivp_level_map.v
// Effective priority level of each vector from its assigned level, or fixed for vectors 0-5 and 14-16
`timescale 1ns/100ps
`default_nettype none
`include "ivp_regs.vh"
module ivp_level_map #(
	parameter NUM_VEC = `IVP_NUM_VEC
) (
	input  wire [2*NUM_VEC-1:0] levelIn,
	input  wire [NUM_VEC-1:0]   reqIn,
	output wire [2*NUM_VEC-1:0] levelOut,
	output wire [NUM_VEC-1:0]   reqOut
);
	localparam [NUM_VEC-1:0] RSV = `IVP_RSV_MASK;
	genvar i;
	generate
		for (i = 0; i < NUM_VEC; i = i + 1) begin : gLvl
			wire [1:0] asg;
			reg  [1:0] eff;
			assign asg = levelIn[2*i+1:2*i];
			always @* begin
				if (i <= 5) begin
					eff = `IVP_LVL_FIXED; // RQ6
				end else if (i <= 11) begin
					// Debug sources never drop below level one
					eff = (asg < `IVP_LVL_DBG_MIN) ? `IVP_LVL_DBG_MIN : asg; // RQ7
				end else if (i == 14) begin
					eff = 2'h2;
				end else if (i == 15) begin
					eff = 2'h1;
				end else if (i == 16) begin
					eff = 2'h0;
				end else begin
					// Clamp: peripherals cannot reach level three
					eff = (asg > `IVP_LVL_PER_MAX) ? `IVP_LVL_PER_MAX : asg; // RQ8
				end
			end
			assign levelOut[2*i+1:2*i] = eff;
			assign reqOut[i] = reqIn[i] & ~RSV[i]; // RQ5 RQ14
		end
	endgenerate
endmodule
`default_nettype wire

// File: core/ivp_arbiter.v
// Level then lowest-number arbiter over all vectors
`timescale 1ns/100ps
`default_nettype none
module ivp_arbiter #(
	parameter NUM_VEC = 47,
	parameter VEC_W   = 6
) (
	input  wire [NUM_VEC-1:0]   req,
	input  wire [2*NUM_VEC-1:0] level,
	output reg                  found,
	output reg  [VEC_W-1:0]     vecNum,
	output reg  [1:0]           vecLvl
);
	integer i;
	integer l;
	always @* begin
		found  = 1'b0;
		vecNum = {VEC_W{1'b0}};
		vecLvl = 2'h0;
		// Highest level first, then scan downward so the lowest number is taken last and wins
		for (l = 3; l >= 0; l = l - 1) begin
			for (i = NUM_VEC - 1; i >= 0; i = i - 1) begin
				if (!found && req[i] && level[2*i+:2] == l[1:0]) begin // RQ1 RQ2
					vecNum = i[VEC_W-1:0];
					vecLvl = l[1:0];
				end
			end
			if (vecNum != {VEC_W{1'b0}} || (req[0] && level[1:0] == l[1:0]))
				found = 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: core/ivp_top.v
// Interrupt priority resolver and vector address generator
// What this block does
// RQ1: Higher priority levels always served first
// RQ2: Same level: smallest vector number wins
// RQ3: Fetch address is base plus offset
// RQ4: Offset is twice the vector number
// RQ5: Vectors zero and one never interrupt
// RQ6: Core exceptions two to five fixed level three
// RQ7: Debug sources take levels one to three
// RQ8: Peripheral sources take levels zero to two
// RQ9: Flash raises vectors twenty-two to twenty-four
// RQ10: CAN raises vectors twenty-six to twenty-nine
// RQ11: SPI units raise vectors thirty-eight to forty-one
// RQ12: Serial unit raises 42,43,45,46
// RQ13: Vector entry addresses only nineteen bits
// RQ14: Reserved vectors never presented as active
`timescale 1ns/100ps
`default_nettype none
`include "ivp_regs.vh"
module ivp_top #(
	parameter NUM_VEC = `IVP_NUM_VEC,
	parameter ADDR_W  = `IVP_ADDR_W
) (
	input  wire                 clk,
	input  wire                 nrst,
	input  wire [ADDR_W-1:0]    vectorBase,
	input  wire [3:0]           coreExc,
	input  wire [4:0]           dbgReq,
	input  wire [2:0]           swReq,
	input  wire                 extReqA,
	input  wire                 extReqB,
	input  wire                 lowVoltReq,
	input  wire                 clkGenReq,
	input  wire [2:0]           flashReq,
	input  wire [3:0]           canReq,
	input  wire [5:0]           gpioReq,
	input  wire [1:0]           spiUnit1Req,
	input  wire [1:0]           spiUnit0Req,
	input  wire [3:0]           serial1Req,
	input  wire [2*NUM_VEC-1:0] levelCfg,
	input  wire [1:0]           coreLevel,
	output reg                  irqValid_r,
	output reg  [5:0]           irqVec_r,
	output reg  [1:0]           irqLevel_r,
	output reg  [ADDR_W-1:0]    irqAddr_r
);
	wire [NUM_VEC-1:0]   rawReq;
	wire [NUM_VEC-1:0]   cleanReq;
	wire [2*NUM_VEC-1:0] effLvl;
	wire                 found;
	wire [5:0]           winVec;
	wire [1:0]           winLvl;
	wire [ADDR_W-1:0]    offset;
	wire [ADDR_W-1:0]    sum;

	// Request vector in table order
	assign rawReq[1:0]   = 2'h0; // RQ5
	assign rawReq[5:2]   = coreExc;
	assign rawReq[7:6]   = dbgReq[1:0];
	assign rawReq[8]     = 1'b0;
	assign rawReq[11:9]  = dbgReq[4:2];
	assign rawReq[13:12] = 2'h0;
	assign rawReq[16:14] = swReq;
	assign rawReq[17]    = extReqA;
	assign rawReq[18]    = extReqB;
	assign rawReq[19]    = 1'b0;
	assign rawReq[20]    = lowVoltReq;
	assign rawReq[21]    = clkGenReq;
	assign rawReq[24:22] = flashReq; // RQ9
	assign rawReq[25]    = 1'b0;
	assign rawReq[29:26] = canReq; // RQ10
	assign rawReq[35:30] = gpioReq;
	assign rawReq[37:36] = 2'h0;
	assign rawReq[39:38] = spiUnit1Req; // RQ11
	assign rawReq[41:40] = spiUnit0Req; // RQ11
	assign rawReq[43:42] = serial1Req[1:0]; // RQ12
	assign rawReq[44]    = 1'b0; // RQ12
	assign rawReq[46:45] = serial1Req[3:2]; // RQ12

	ivp_level_map #(
		.NUM_VEC (NUM_VEC)
	) uMap (
		.levelIn  (levelCfg),
		.reqIn    (rawReq),
		.levelOut (effLvl),
		.reqOut   (cleanReq)
	);

	ivp_arbiter #(
		.NUM_VEC (NUM_VEC),
		.VEC_W   (6)
	) uArb (
		.req    (cleanReq),
		.level  (effLvl),
		.found  (found),
		.vecNum (winVec),
		.vecLvl (winLvl)
	);

	// Two words per entry; entries only reach nineteen address bits
	assign offset = {{(ADDR_W-7){1'b0}}, winVec, 1'b0}; // RQ4
	assign sum    = vectorBase + offset; // RQ3

	// Only requests at or above the core's current mask are presented,
	// except level three which cannot be masked
	always @(posedge clk) begin
		if (!nrst) begin
			irqValid_r <= 1'b0;
			irqVec_r   <= 6'h00;
			irqLevel_r <= 2'h0;
			irqAddr_r  <= `IVP_BASE_RESET;
		end else begin
			irqValid_r <= found && (winLvl >= coreLevel ||
				winLvl == `IVP_LVL_FIXED);
			irqVec_r   <= winVec;
			irqLevel_r <= winLvl;
			irqAddr_r  <= {{(ADDR_W-`IVP_VEC_ADDR_W){1'b0}},
				sum[`IVP_VEC_ADDR_W-1:0]}; // RQ13
		end
	end
endmodule
`default_nettype wire

// File: test/ivp_chk_sva.sv
// Checker for the vector priority resolver
`timescale 1ns/100ps
`default_nettype none
`include "ivp_regs.vh"
module ivp_chk_sva (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [20:0] vectorBase,
	input wire logic [3:0]  coreExc,
	input wire logic [2:0]  flashReq,
	input wire logic        irqValid_r,
	input wire logic [5:0]  irqVec_r,
	input wire logic [1:0]  irqLevel_r,
	input wire logic [20:0] irqAddr_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic [46:0] rsv = `IVP_RSV_MASK;
	exc_level_a: assert property (|coreExc |=> irqLevel_r == 2'h3)
		else $error("exception level wrong");
	exc_first_a: assert property (coreExc[0] |=> irqVec_r == 6'h02)
		else $error("lowest exception lost");
	addr_form_a: assert property (irqValid_r |-> irqAddr_r[18:0] ==
		19'($past(vectorBase) + 21'(irqVec_r) * 2)) else $error("bad addr");
	addr_high_a: assert property (irqAddr_r[20:19] == 2'h0)
		else $error("address above nineteen bits");
	no_rsv_a: assert property (irqValid_r |-> !rsv[irqVec_r])
		else $error("reserved vector shown");
	dbg_level_a: assert property (irqValid_r && irqVec_r inside {[6:11]}
		|-> irqLevel_r != 2'h0) else $error("debug level low");
	per_level_a: assert property (irqValid_r && irqVec_r > 16
		|-> irqLevel_r != 2'h3) else $error("peripheral level high");
	lvl_order_a: assert property (irqValid_r && irqLevel_r != 3
		|-> $past(coreExc) == 0) else $error("level order broken");
	flash_src_a: assert property (irqValid_r && irqVec_r == 6'h16
		|-> $past(flashReq[0])) else $error("flash vector w/o request");
	cover property (irqValid_r && irqVec_r == 6'h14);
	cover property (irqValid_r && irqLevel_r == 2'h0);
	cover property (!irqValid_r && irqVec_r != 0);
endmodule
bind ivp_top ivp_chk_sva chk_u (.*);
`default_nettype wire

// File: test/ivp_core_model.sv
// Core model that sets the interrupt mask level
`timescale 1ns/100ps
`default_nettype none
module ivp_core_model (
	input  wire logic       clk,
	input  wire logic [1:0] lvlSet,
	output var logic  [1:0] coreLevel = 2'h0
);
	// Mask moves on the edge only, like a core status update
	always @(posedge clk) begin
		coreLevel <= lvlSet;
	end
endmodule
`default_nettype wire

// File: test/ivp_top_tb.sv
// Bench for the vector priority resolver
`timescale 1ns/100ps
`default_nettype none
`include "ivp_regs.vh"
module ivp_top_tb;
	logic        clk = 0, nrst = 0;
	logic [46:0] rq = 0;
	logic [93:0] levelCfg = 0;
	logic [20:0] vectorBase = 0;
	logic [1:0]  lvlSet = 0, coreLevel;
	wire  [3:0]  coreExc = rq[5:2], canReq = rq[29:26];
	wire  [4:0]  dbgReq = {rq[11:9], rq[7:6]};
	wire  [2:0]  swReq = rq[16:14], flashReq = rq[24:22];
	wire         extReqA = rq[17], extReqB = rq[18];
	wire         lowVoltReq = rq[20], clkGenReq = rq[21];
	wire  [5:0]  gpioReq = rq[35:30];
	wire  [1:0]  spiUnit1Req = rq[39:38], spiUnit0Req = rq[41:40];
	wire  [3:0]  serial1Req = {rq[46:45], rq[43:42]};
	wire         irqValid_r;
	wire  [5:0]  irqVec_r;
	wire  [1:0]  irqLevel_r;
	wire  [20:0] irqAddr_r;
	int          ev, el, cyc = 0, seed = 96410, err_total = 0, checked = 0;
	ivp_top dut_u (.*);
	ivp_core_model core_u (.*);
	always #2.5 clk = ~clk;
	always @(posedge clk) if (++cyc > 10000) begin err_total++; close_out; end
	function automatic int lv(int i);
		int c;
		c = levelCfg[2*i+:2];
		if (i < 6) return 3;
		if (i < 12) return c < 1 ? 1 : c;
		if (i < 17) return 16 - i;
		return c > 2 ? 2 : c;
	endfunction
	task automatic cmp(logic [20:0] got, logic [20:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Outputs follow the inputs of the previous edge, so sample them late
	task automatic step(logic [46:0] v);
		logic [20:0] b;
		logic [1:0] cl;
		rq = v & ~`IVP_RSV_MASK;
		b = vectorBase;
		cl = coreLevel;
		ev = -1;
		el = -1;
		for (int i = 2; i < 47; i++)
			if (rq[i] && lv(i) > el) begin ev = i; el = lv(i); end
		@(negedge clk);
		cmp(irqValid_r, ev >= 0 && (el == 3 || el >= cl));
		if (ev >= 0) begin
			cmp(irqVec_r, ev);
			cmp(irqLevel_r, el);
			cmp(irqAddr_r, (b + 2 * ev) & 21'h7ffff);
		end
	endtask
	task automatic close_out;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		cmp(irqAddr_r, 0);
		nrst = 1;
		step(0);
		$display("reset done");
		levelCfg[41:40] = 2'h2;
		vectorBase = 21'h000400;
		step(47'h1 << 20);
		cmp(irqAddr_r, 21'h000428);
		$display("walk done");
		for (int i = 2; i < 47; i++) begin
			levelCfg = {$random(seed), $random(seed), $random(seed)};
			step(47'h1 << i);
		end
		$display("sweep done");
		for (int k = 0; k < 2000; k++) begin
			levelCfg = {$random(seed), $random(seed), $random(seed)};
			vectorBase = $random(seed);
			lvlSet = $random(seed);
			step({$random(seed), $random(seed)} & {$random(seed), $random(seed)});
		end
		$display("random done");
		nrst = 0;
		repeat (2) @(negedge clk);
		cmp(irqValid_r, 0);
		nrst = 1;
		step(47'h1 << 2);
		$display("rereset done");
		close_out;
	end
endmodule
`default_nettype wire
